// >>> verification/gate_board_model.sv
/*
   Behavioural model of the six-driver gate board: wired fault and ready
   lines, fault lockout, reset pulse filter and inverted supply enable.
   Assumes the bench drives desaturation and undervoltage per channel.
*/
`timescale 1ns/1ps
`default_nettype none

module gate_board_model (
   input wire logic [5:0] PWM_IN,
   input wire logic RESET_N,
   input wire logic ENABLE_N,
   input wire logic [5:0] DESAT,
   input wire logic [5:0] UNDERVOLT,
   output logic FAULT_N,
   output logic READY,
   output logic [5:0] GATE
);
   logic [5:0] locked = 6'h00;
   logic [5:0] pwm_filt;
   logic supply_on;
   realtime low_start = 0.0;

   assign supply_on = ~ENABLE_N;
   assign #21 pwm_filt = PWM_IN;
   assign GATE = pwm_filt & ~locked & {6{supply_on}};
   always @(DESAT or GATE) locked = locked | (DESAT & GATE);
   always @(negedge RESET_N) low_start = $realtime;
   always @(posedge RESET_N) begin
      if ($realtime - low_start >= 800.0) locked = 6'h00;
   end
   assign FAULT_N = (locked == 6'h00);
   // ready only when all supplies good
   assign READY = supply_on && (UNDERVOLT == 6'h00);
endmodule : gate_board_model
`default_nettype wire

// >>> verification/gate_host_ctrl_bench.sv
/*
   Self-checking bench for the gate-driver board controller.
   Assumes the board model closes the loop on fault, ready and enable.
*/
`timescale 1ns/1ps
`default_nettype none

module gate_host_ctrl_bench;
   import gate_host_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [5:0] pwm_cmd = 6'h00;
   logic [5:0] pwm_out;
   logic [5:0] desat = 6'h00;
   logic [5:0] undervolt = 6'h00;
   logic [5:0] gate;
   logic fault_n, ready, emerg = 1'b0, rst_n_pin, en_n_pin;
   int err_total = 0;
   int tests_run = 0;
   int n;

   gate_host_ctrl uut (.REF_CLK(clk), .RESET(rst), .BUS_ADDR(addr),
      .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata),
      .PWM_CMD(pwm_cmd), .PWM_OUT(pwm_out), .FAULT_N_IN(fault_n),
      .READY_IN(ready), .EMERGENCY_IN(emerg),
      .GATE_RESET_N_OUT(rst_n_pin), .SUPPLY_ENABLE_N_OUT(en_n_pin));

   gate_board_model board (.PWM_IN(pwm_out), .RESET_N(rst_n_pin),
      .ENABLE_N(en_n_pin), .DESAT(desat), .UNDERVOLT(undervolt),
      .FAULT_N(fault_n), .READY(ready), .GATE(gate));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t register %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t pins %h expected %h", $time, got, exp);
      end
   endtask : chk_pin

   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk_reg(rdata, exp);
   endtask : rd_chk

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      cyc(4);
      chk_pin({pwm_out, rst_n_pin, en_n_pin}, 8'h02);
      rd_chk(OFF_STATUS, 32'h0000_0002);
      rd_chk(OFF_CTRL, 32'h0000_0000);
      rd_chk(OFF_PWM_MASK, 32'h0000_0000);
      rd_chk(4'h1, 32'h0000_0000);
      // Mask applied bitwise, unmapped write ignored
      pwm_cmd <= 6'h2A;
      wr_reg(OFF_CTRL, 32'h0000_0001);
      wr_reg(OFF_PWM_MASK, 32'h0000_003F);
      wr_reg(4'h2, 32'h0000_0000);
      cyc(3);
      chk_pin({2'b00, gate}, 8'h2A);
      wr_reg(OFF_PWM_MASK, 32'h0000_000F);
      cyc(3);
      chk_pin({2'b00, pwm_out}, 8'h0A);
      // Desaturation on channel 3 locks the board out
      wr_reg(OFF_PWM_MASK, 32'h0000_003F);
      pwm_cmd <= 6'h08;
      cyc(3);
      desat <= 6'h08;
      cyc(5);
      chk_pin({fault_n, 1'b0, pwm_out}, 8'h00);
      desat <= 6'h00;
      cyc(4);
      chk_pin({fault_n, 1'b0, gate}, 8'h00);
      rd_chk(OFF_STATUS, 32'h0000_0007);
      // Second request while busy must not stretch the pulse
      wr_reg(OFF_CTRL, 32'h0000_0005);
      wr_reg(OFF_CTRL, 32'h0000_0005);
      #1;
      n = 2;
      while (rst_n_pin === 1'b0 && n < 300) begin
         cyc(1);
         n++;
      end
      chk_reg(n, RESET_LOW_CYC);
      rd_chk(OFF_CTRL, 32'h0000_0001);
      cyc(5);
      chk_pin({fault_n, 1'b0, pwm_out}, 8'h88);
      rd_chk(OFF_STATUS, 32'h0000_0006);
      wr_reg(OFF_CLEAR, 32'h0000_0004);
      rd_chk(OFF_STATUS, 32'h0000_0002);
      // Undervoltage on one driver drops the shared ready line
      undervolt <= 6'h20;
      cyc(5);
      chk_pin({ready, 1'b0, pwm_out}, 8'h00);
      undervolt <= 6'h00;
      rd_chk(OFF_STATUS, 32'h0000_0040);
      cyc(4);
      wr_reg(OFF_CLEAR, 32'h0000_0040);
      rd_chk(OFF_STATUS, 32'h0000_0002);
      // Software shutdown request
      wr_reg(OFF_CTRL, 32'h0000_0003);
      cyc(5);
      chk_pin({en_n_pin, ready, pwm_out}, 8'h80);
      rd_chk(OFF_STATUS, 32'h0000_0050);
      wr_reg(OFF_CTRL, 32'h0000_0001);
      cyc(5);
      wr_reg(OFF_CLEAR, 32'h0000_0040);
      rd_chk(OFF_STATUS, 32'h0000_0002);
      // Emergency pin latches shutdown until cleared
      emerg <= 1'b1;
      cyc(2);
      emerg <= 1'b0;
      cyc(6);
      chk_pin({en_n_pin, 1'b0, gate}, 8'h80);
      rd_chk(OFF_STATUS, 32'h0000_0070);
      wr_reg(OFF_CLEAR, 32'h0000_0020);
      cyc(6);
      wr_reg(OFF_CLEAR, 32'h0000_0040);
      cyc(4);
      chk_pin({en_n_pin, 1'b0, pwm_out}, 8'h08);
      rd_chk(OFF_STATUS, 32'h0000_0002);
      print_verdict();
   end
endmodule : gate_host_ctrl_bench
`default_nettype wire

// >>> verilog/gate_host_ctrl.sv
/*
   Controller for a six-channel isolated gate-driver board: PWM gating,
   shared fault and ready monitoring, lockout reset pulse and
   supply-enable shutdown, with a small software register port.
   Assumes the board pulls the shared fault and ready lines up to 3.3 V
   and that PWM_CMD comes from logic on REF_CLK.
*/
// The address map and the strobed register port were decided locally.
// Summary of operation
// R1 - A driver pulls the fault line low on IGBT desaturation.
// R2 - Fault line is open-drain active low, pulled up on controller side.
// R3 - Six fault outputs share one line, low when any driver faults.
// R4 - Ready is active high, low when either supply is undervoltage.
// R5 - Shared ready line is high only when all six drivers ready.
// R6 - A faulted driver stays locked out until a valid reset pulse.
// R7 - Controller drives the reset line low at least 800 ns.
// R8 - Driver reset input filters noise and short glitches.
// R9 - One controller pin drives all six driver resets together.
// R10 - Gate output follows the PWM level non-inverted.
// R11 - PWM inputs are driven push-pull, never open-drain.
// R12 - Drivers ignore control pulses of 20 ns or less.
// R13 - Gate clamp engages only when commanded off and gate below 2 V.
// R14 - Supply enable is active low; high requests shutdown.
// R15 - Level translator inverts enable; high input shuts converters down.
// R16 - Inverted enable also shuts down the primary 3.3 V regulator.
// R17 - Controller uses the enable line for safe torque off on emergency.
// R18 - Hold PWM low while fault is low; reset only after handling.
`timescale 1ns/1ps
`default_nettype none

module gate_host_ctrl
   import gate_host_pkg::*;
#(
   parameter int unsigned RESET_LOW_CYCLES = gate_host_pkg::RESET_LOW_CYC
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic [gate_host_pkg::ADDR_W-1:0] BUS_ADDR,
   input wire logic [gate_host_pkg::DATA_W-1:0] BUS_WDATA,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   output logic [gate_host_pkg::DATA_W-1:0] BUS_RDATA,
   input wire logic [gate_host_pkg::CHANNELS-1:0] PWM_CMD,
   output logic [gate_host_pkg::CHANNELS-1:0] PWM_OUT,
   input wire logic FAULT_N_IN,
   input wire logic READY_IN,
   input wire logic EMERGENCY_IN,
   output logic GATE_RESET_N_OUT,
   output logic SUPPLY_ENABLE_N_OUT
);
   import gate_host_pkg::*;

   localparam int unsigned CNT_W = 8;

   // Elaboration checks; a shorter pulse would not clear the lockout
   if (RESET_LOW_CYCLES < RESET_LOW_CYC
       || RESET_LOW_CYCLES > 255) begin : g_bad_len
      $error("RESET_LOW_CYCLES outside the range the counter serves");
   end
   if (GLITCH_CYC > 1) begin : g_bad_glitch
      $error("Registered PWM cannot guarantee the glitch-filter margin");
   end

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
      addr_hit = (a == off);
   endfunction : addr_hit

   // Synchronised pin levels
   logic [2:0] pins_sync;
   logic fault_low;
   logic ready_ok;
   logic emergency;

   // Registers
   logic [1:0] ctrl_reg;
   logic [CHANNELS-1:0] pwm_mask_reg;
   logic fault_seen_reg;
   logic emerg_seen_reg;
   logic not_ready_seen_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [CHANNELS-1:0] pwm_reg;
   logic enable_n_reg;
   pulse_state_t pulse_state_reg;
   pulse_state_t pulse_state_next;
   logic [CNT_W-1:0] pulse_cnt_reg;
   logic [CNT_W-1:0] pulse_cnt_next;

   // Decode
   wire wr_ctrl = BUS_WR && addr_hit(BUS_ADDR, OFF_CTRL);
   wire wr_clear = BUS_WR && addr_hit(BUS_ADDR, OFF_CLEAR);
   wire wr_mask = BUS_WR && addr_hit(BUS_ADDR, OFF_PWM_MASK);
   wire reset_go = wr_ctrl && BUS_WDATA[CTRL_RESET_GO];
   wire clr_fault = wr_clear && BUS_WDATA[ST_FAULT_SEEN];
   wire clr_emerg = wr_clear && BUS_WDATA[ST_EMERG_SEEN];
   wire clr_not_ready = wr_clear && BUS_WDATA[ST_NOT_READY_SEEN];
   wire pulse_busy = (pulse_state_reg == PULSE_LOW);
   wire safe_torque_off = ctrl_reg[CTRL_SAFE_TORQUE_OFF] || emerg_seen_reg;

   // Fault and ready lines arrive asynchronously from the board
   pin_sync #(
      .WIDTH(3),
      .RESET_VALUE(3'h3)
   ) u_pin_sync (
      .CLK(REF_CLK),
      .RST(RESET),
      .ASYNC_IN({EMERGENCY_IN, READY_IN, FAULT_N_IN}),
      .SYNC_OUT(pins_sync)
   );

   // R2 fault line active low
   // R3 any driver pulls it
   assign fault_low = !pins_sync[0];
   // R5 shared ready high only when all ready
   assign ready_ok = pins_sync[1];
   assign emergency = pins_sync[2];

   // R18 gate PWM on fault
   // R4 undervoltage blocks PWM
   // R6 hold off through lockout
   wire pwm_allowed = ctrl_reg[CTRL_PWM_EN] && !fault_low && ready_ok
                      && !safe_torque_off && !pulse_busy;
   // R10 non-inverted PWM level
   wire [CHANNELS-1:0] pwm_next = pwm_allowed ? (PWM_CMD & pwm_mask_reg)
                                              : {CHANNELS{1'b0}};

   // R11 push-pull outputs
   // R12 registered, so every pulse spans a full 25 ns period
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         pwm_reg <= 6'h00;
      end else begin
         pwm_reg <= pwm_next;
      end
   end
   assign PWM_OUT = pwm_reg;

   // Control and mask registers
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         ctrl_reg <= CTRL_RESET;
         pwm_mask_reg <= PWM_MASK_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= BUS_WDATA[1:0];
         end
         if (wr_mask) begin
            pwm_mask_reg <= BUS_WDATA[CHANNELS-1:0];
         end
      end
   end

   // R1 sticky fault, set beats clear
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         fault_seen_reg <= 1'b0;
         not_ready_seen_reg <= 1'b0;
      end else begin
         fault_seen_reg <= fault_low || (fault_seen_reg && !clr_fault);
         not_ready_seen_reg <= !ready_ok
                               || (not_ready_seen_reg && !clr_not_ready);
      end
   end

   // R17 emergency latches safe torque off
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         emerg_seen_reg <= 1'b0;
      end else begin
         emerg_seen_reg <= emergency || (emerg_seen_reg && !clr_emerg);
      end
   end

   // R14 active-low enable, high shuts down
   // R15 board inverts it
   // R16 primary regulator follows
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         enable_n_reg <= 1'b0;
      end else begin
         enable_n_reg <= safe_torque_off;
      end
   end
   assign SUPPLY_ENABLE_N_OUT = enable_n_reg;

   // R7 low pulse counter
   always_comb begin
      pulse_state_next = pulse_state_reg;
      pulse_cnt_next = pulse_cnt_reg;
      case (pulse_state_reg)
         PULSE_IDLE: begin
            if (reset_go) begin
               pulse_state_next = PULSE_LOW;
               pulse_cnt_next = CNT_W'(RESET_LOW_CYCLES - 1);
            end
         end
         PULSE_LOW: begin
            if (pulse_cnt_reg == '0) begin
               pulse_state_next = PULSE_IDLE;
            end else begin
               pulse_cnt_next = pulse_cnt_reg - 1'b1;
            end
         end
         default: begin
            pulse_state_next = PULSE_IDLE;
            pulse_cnt_next = '0;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         pulse_state_reg <= PULSE_IDLE;
         pulse_cnt_reg <= '0;
      end else begin
         pulse_state_reg <= pulse_state_next;
         pulse_cnt_reg <= pulse_cnt_next;
      end
   end

   // R9 one pin for all six resets
   assign GATE_RESET_N_OUT = !pulse_busy;

   // Read data; unmapped words read as zero
   wire [DATA_W-1:0] status_word = {25'h000_0000,
                                    not_ready_seen_reg,
                                    emerg_seen_reg,
                                    safe_torque_off,
                                    pulse_busy,
                                    fault_seen_reg,
                                    ready_ok,
                                    fault_low};
   wire [DATA_W-1:0] read_mux =
      addr_hit(BUS_ADDR, OFF_CTRL) ? {30'h0000_0000, ctrl_reg} :
      addr_hit(BUS_ADDR, OFF_STATUS) ? status_word :
      addr_hit(BUS_ADDR, OFF_PWM_MASK) ? {26'h000_0000, pwm_mask_reg} :
      32'h0000_0000;

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= BUS_RD ? read_mux : 32'h0000_0000;
      end
   end
   assign BUS_RDATA = rdata_reg;

   // Checks
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);

   AST_FAULT_BLOCKS_PWM: assert property ( // R18
      fault_low |=> (PWM_OUT == 6'h00))
      else $error("PWM active while fault line low");

   AST_FAULT_PIN_TO_PWM: assert property ( // R3
      !FAULT_N_IN [*3] |=> (PWM_OUT == 6'h00))
      else $error("PWM not stopped three cycles after fault pin low");

   AST_FAULT_STICKY: assert property ( // R1
      fault_low |=> fault_seen_reg)
      else $error("Fault not latched in status");

   AST_NOT_READY_BLOCKS: assert property ( // R4
      !ready_ok |=> (PWM_OUT == 6'h00) && not_ready_seen_reg)
      else $error("PWM active while drivers not ready");

   AST_PWM_FOLLOWS: assert property ( // R10
      pwm_allowed |=> (PWM_OUT == $past(PWM_CMD & pwm_mask_reg)))
      else $error("PWM output does not follow command");

   // R7 low-time helper counter
   logic [CNT_W-1:0] low_len_reg;
   always_ff @(posedge REF_CLK) begin
      if (RESET || GATE_RESET_N_OUT) begin
         low_len_reg <= '0;
      end else begin
         low_len_reg <= low_len_reg + 1'b1;
      end
   end

   AST_RESET_LOW_HOLD: assert property ( // R7
      $rose(GATE_RESET_N_OUT) |-> (low_len_reg == CNT_W'(RESET_LOW_CYCLES)))
      else $error("Reset pulse low time differs from RESET_LOW_CYCLES");

   AST_RESET_START: assert property ( // R9
      reset_go && !pulse_busy |=> !GATE_RESET_N_OUT)
      else $error("Reset pulse did not start");

   AST_LOCKOUT_PWM: assert property ( // R6
      !GATE_RESET_N_OUT |=> (PWM_OUT == 6'h00))
      else $error("PWM driven during reset pulse");

   AST_SAFE_TORQUE_OFF_ENABLE: assert property ( // R14
      safe_torque_off |=> SUPPLY_ENABLE_N_OUT ##0 (PWM_OUT == 6'h00))
      else $error("Shutdown not requested during safe torque off");

   AST_EMERGENCY_STO: assert property ( // R17
      emergency |=> ##1 SUPPLY_ENABLE_N_OUT)
      else $error("Emergency did not shut supplies down");

   AST_READ_IDLE_ZERO: assert property (
      !$past(BUS_RD) |-> (BUS_RDATA == 32'h0000_0000))
      else $error("Read data outside read cycle");

   COV_FAULT_THEN_RESET: cover property (
      fault_low ##[1:200] $fell(GATE_RESET_N_OUT));
   COV_SAFE_TORQUE_OFF: cover property ($rose(SUPPLY_ENABLE_N_OUT));
   COV_PWM_RUN: cover property (pwm_allowed ##1 (PWM_OUT != 6'h00));
   COV_CLEAR_RACE: cover property (fault_low && clr_fault);

endmodule : gate_host_ctrl

`default_nettype wire

// >>> verilog/gate_host_pkg.sv
/*
   Shared constants for the gate-driver board controller: register map,
   field positions, reset values and pulse timing.
   Assumes a 40 MHz REF_CLK and a 4-bit byte-addressed software port.
*/
`default_nettype none

package gate_host_pkg;

   localparam int unsigned CHANNELS = 6;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 4;

   // Clock and pin timing
   localparam int unsigned CLK_PERIOD_PS = 25000;
   localparam int unsigned RESET_LOW_NS = 800;
   localparam int unsigned RESET_LOW_CYC =
      (RESET_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned GLITCH_NS = 20;
   localparam int unsigned GLITCH_CYC = (GLITCH_NS * 1000) / CLK_PERIOD_PS + 1;
   localparam int unsigned SYNC_STAGES = 2;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_CLEAR = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_PWM_MASK = 4'hC;

   // Control fields
   localparam int unsigned CTRL_PWM_EN = 0;
   localparam int unsigned CTRL_SAFE_TORQUE_OFF = 1;
   localparam int unsigned CTRL_RESET_GO = 2;

   // Status fields
   localparam int unsigned ST_FAULT_LOW = 0;
   localparam int unsigned ST_READY = 1;
   localparam int unsigned ST_FAULT_SEEN = 2;
   localparam int unsigned ST_RESET_BUSY = 3;
   localparam int unsigned ST_SAFE_TORQUE_OFF = 4;
   localparam int unsigned ST_EMERG_SEEN = 5;
   localparam int unsigned ST_NOT_READY_SEEN = 6;

   // Reset values
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [CHANNELS-1:0] PWM_MASK_RESET = 6'h00;

   typedef enum logic [0:0] {
      PULSE_IDLE = 1'b0,
      PULSE_LOW = 1'b1
   } pulse_state_t;

endpackage : gate_host_pkg

`default_nettype wire

// >>> verilog/pin_sync.sv
/*
   Two-flop synchroniser for a group of board input pins.
   Assumes the inputs are asynchronous levels; only the second stage
   is read outside this module.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int unsigned WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [WIDTH-1:0] ASYNC_IN,
   output logic [WIDTH-1:0] SYNC_OUT
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // Elaboration check on the width
   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs at least one bit");
   end

   // Metastability guard; stage1 feeds stage2 only
   always_ff @(posedge CLK) begin
      if (RST) begin
         stage1_reg <= RESET_VALUE;
         stage2_reg <= RESET_VALUE;
      end else begin
         stage1_reg <= ASYNC_IN;
         stage2_reg <= stage1_reg;
      end
   end

   assign SYNC_OUT = stage2_reg;

endmodule : pin_sync

`default_nettype wire
